// ===== rtl/dcb_channel.sv
// Channel B DDR SDRAM pin interface: command clocks, selects, clock enables,
// command encoding, write data with centred strobes and strobe-timed read capture.
// Assumes one user drives requests on clk; DIMM pins resolve outside this file.
`timescale 1ns/10ps
`default_nettype none
module dcb_channel #(
  parameter int INIT_CYCLES = dcb_pkg::INIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire dcb_pkg::dcb_cmd_t reqCmd,
  input wire logic [1:0] reqRow,
  input wire logic [1:0] reqBank,
  input wire logic [12:0] reqAddr,
  input wire logic [63:0] reqWrData0,
  input wire logic [63:0] reqWrData1,
  input wire logic suspendReq,
  output logic selfRefreshActive,
  output logic initDone,
  output logic rdValid,
  output logic [127:0] rdData,
  output logic [5:0] cmdClockPairB,
  output logic [5:0] cmdClockPairBN,
  output logic [3:0] rowSelectBN,
  output logic [12:0] memAddrB,
  output logic [5:1] memAddrDupB,
  output logic [1:0] bankAddrB,
  output logic rowStrobeBN,
  output logic columnStrobeBN,
  output logic writeEnableBN,
  output logic [3:0] rowClockEnableB,
  input wire logic [63:0] memDataBIn,
  output logic [63:0] memDataBOut,
  output logic memDataBOe,
  input wire logic [7:0] byteStrobeBIn,
  output logic [7:0] byteStrobeBOut,
  output logic byteStrobeBOe
);
  // ----------------------------------------------------------------
  // Command side state
  // ----------------------------------------------------------------
  logic [1:0] phase, next_phase;
  logic cmdClk, next_cmdClk;
  dcb_pkg::dcb_state_t state, next_state;
  logic [15:0] initCnt, next_initCnt;
  logic [7:0] idleCnt, next_idleCnt;
  logic [3:0] cke, next_cke;
  logic [3:0] selN, next_selN;
  logic [2:0] cmdPins, next_cmdPins;
  logic [12:0] addr, next_addr;
  logic [1:0] bank, next_bank;
  logic [63:0] dataOut, next_dataOut;
  logic dataOe, next_dataOe;
  logic [7:0] dqsOut, next_dqsOut;
  logic dqsOe, next_dqsOe;
  dcb_pkg::dcb_cmd_t lCmd, next_lCmd;
  logic [1:0] lRow, next_lRow;
  logic [1:0] lBank, next_lBank;
  logic [12:0] lAddr, next_lAddr;
  logic [63:0] lWd0, next_lWd0;
  logic [63:0] lWd1, next_lWd1;
  logic atEdge;
  logic reqTake;
  logic needWake;

  // Command pins per code
  function automatic logic [2:0] encodeCmd(input dcb_pkg::dcb_cmd_t c);
    case (c)
      dcb_pkg::CMD_ACT: encodeCmd = dcb_pkg::PINS_ACT;
      dcb_pkg::CMD_RD: encodeCmd = dcb_pkg::PINS_RD;
      dcb_pkg::CMD_WR: encodeCmd = dcb_pkg::PINS_WR;
      dcb_pkg::CMD_PRE: encodeCmd = dcb_pkg::PINS_PRE;
      dcb_pkg::CMD_REF: encodeCmd = dcb_pkg::PINS_REF;
      dcb_pkg::CMD_MRS: encodeCmd = dcb_pkg::PINS_MRS;
      default: encodeCmd = dcb_pkg::PINS_NOP;
    endcase
  endfunction

  // Refresh and mode set go to every row, the rest to one
  function automatic logic isBroadcast(input dcb_pkg::dcb_cmd_t c);
    isBroadcast = (c == dcb_pkg::CMD_REF) || (c == dcb_pkg::CMD_MRS);
  endfunction

  assign atEdge = (phase == dcb_pkg::PH_LAST);
  assign reqReady = (state == dcb_pkg::ST_IDLE) && !suspendReq;
  assign reqTake = reqValid && reqReady;
  assign needWake = isBroadcast(reqCmd) ? (cke != dcb_pkg::CKE_ALL) : !cke[reqRow];

  always_comb begin
    next_phase = 2'(phase + 2'h1);
    next_cmdClk = (next_phase == dcb_pkg::PH_RISE) || (next_phase == dcb_pkg::PH_DQS_UP);
    next_state = state;
    next_initCnt = initCnt;
    next_idleCnt = idleCnt;
    next_cke = cke;
    next_selN = selN;
    next_cmdPins = cmdPins;
    next_addr = addr;
    next_bank = bank;
    next_dataOut = dataOut;
    next_dataOe = dataOe;
    next_dqsOut = dqsOut;
    next_dqsOe = dqsOe;
    next_lCmd = lCmd;
    next_lRow = lRow;
    next_lBank = lBank;
    next_lAddr = lAddr;
    next_lWd0 = lWd0;
    next_lWd1 = lWd1;
    case (state)
      dcb_pkg::ST_INIT: begin
        next_cke = dcb_pkg::CKE_OFF;
        if (initCnt != 16'(INIT_CYCLES - 1)) begin
          next_initCnt = 16'(initCnt + 16'h1);
        end else if (atEdge) begin
          next_cke = dcb_pkg::CKE_ALL;
          next_state = dcb_pkg::ST_IDLE;
        end
      end
      dcb_pkg::ST_IDLE: begin
        if (idleCnt != 8'(dcb_pkg::IDLE_CYC)) begin
          next_idleCnt = 8'(idleCnt + 8'h1);
        end else if (atEdge && !reqTake) begin
          // A take at the timeout edge keeps the enables up for its command
          next_cke = dcb_pkg::CKE_OFF;
        end
        if (suspendReq && atEdge) begin
          // Refresh with enables low enters self-refresh on every row
          next_selN = dcb_pkg::SEL_ALL_N;
          next_cmdPins = dcb_pkg::PINS_REF;
          next_cke = dcb_pkg::CKE_OFF;
          next_state = dcb_pkg::ST_SREF;
        end else if (reqTake) begin
          next_idleCnt = 8'h00;
          next_lCmd = reqCmd;
          next_lRow = reqRow;
          next_lBank = reqBank;
          next_lAddr = reqAddr;
          next_lWd0 = reqWrData0;
          next_lWd1 = reqWrData1;
          next_state = needWake ? dcb_pkg::ST_WAKE : dcb_pkg::ST_ISSUE;
        end
      end
      dcb_pkg::ST_WAKE: begin
        // Enables go up a full command clock before the command
        if (atEdge) begin
          next_cke = dcb_pkg::CKE_ALL;
          next_state = dcb_pkg::ST_ISSUE;
        end
      end
      dcb_pkg::ST_ISSUE: begin
        if (atEdge) begin
          next_selN = isBroadcast(lCmd) ? dcb_pkg::SEL_ALL_N : ~(dcb_pkg::SEL_ONE << lRow);
          next_cmdPins = encodeCmd(lCmd);
          next_addr = lAddr;
          next_bank = lBank;
          next_state = dcb_pkg::ST_CMD;
        end
      end
      dcb_pkg::ST_CMD: begin
        if (atEdge) begin
          next_selN = dcb_pkg::SEL_NONE_N;
          next_cmdPins = dcb_pkg::PINS_NOP;
          next_state = dcb_pkg::ST_IDLE;
          if (lCmd == dcb_pkg::CMD_WR) begin
            next_dataOe = 1'b1;
            next_dqsOe = 1'b1;
            next_dataOut = lWd0;
            next_dqsOut = dcb_pkg::DQS_LOW;
            next_state = dcb_pkg::ST_WDATA;
          end
        end
      end
      dcb_pkg::ST_WDATA: begin
        // Data moves on command clock edges, strobe a quarter later
        if (phase == dcb_pkg::PH_RISE) begin
          next_dqsOut = dcb_pkg::DQS_HIGH;
        end
        if (phase == dcb_pkg::PH_DQS_UP) begin
          next_dataOut = lWd1;
        end
        if (phase == dcb_pkg::PH_FALL) begin
          next_dqsOut = dcb_pkg::DQS_LOW;
        end
        if (atEdge) begin
          next_dataOe = 1'b0;
          next_dqsOe = 1'b0;
          next_idleCnt = 8'h00;
          next_state = dcb_pkg::ST_IDLE;
        end
      end
      dcb_pkg::ST_SREF: begin
        if (atEdge) begin
          next_selN = dcb_pkg::SEL_NONE_N;
          next_cmdPins = dcb_pkg::PINS_NOP;
          if (!suspendReq) begin
            next_cke = dcb_pkg::CKE_ALL;
            next_idleCnt = 8'h00;
            next_state = dcb_pkg::ST_IDLE;
          end
        end
      end
      default: next_state = dcb_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= dcb_pkg::PH_LAST;
      cmdClk <= 1'b0;
      state <= dcb_pkg::ST_INIT;
      initCnt <= 16'h0000;
      idleCnt <= 8'h00;
      cke <= dcb_pkg::CKE_OFF;
      selN <= dcb_pkg::SEL_NONE_N;
      cmdPins <= dcb_pkg::PINS_NOP;
      addr <= 13'h0000;
      bank <= 2'h0;
      dataOut <= 64'h0;
      dataOe <= 1'b0;
      dqsOut <= dcb_pkg::DQS_LOW;
      dqsOe <= 1'b0;
      lCmd <= dcb_pkg::CMD_NOP;
      lRow <= 2'h0;
      lBank <= 2'h0;
      lAddr <= 13'h0000;
      lWd0 <= 64'h0;
      lWd1 <= 64'h0;
    end else begin
      phase <= next_phase;
      cmdClk <= next_cmdClk;
      state <= next_state;
      initCnt <= next_initCnt;
      idleCnt <= next_idleCnt;
      cke <= next_cke;
      selN <= next_selN;
      cmdPins <= next_cmdPins;
      addr <= next_addr;
      bank <= next_bank;
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      dqsOut <= next_dqsOut;
      dqsOe <= next_dqsOe;
      lCmd <= next_lCmd;
      lRow <= next_lRow;
      lBank <= next_lBank;
      lAddr <= next_lAddr;
      lWd0 <= next_lWd0;
      lWd1 <= next_lWd1;
    end
  end

  assign cmdClockPairB = {dcb_pkg::CLK_PAIRS{cmdClk}};
  assign cmdClockPairBN = ~cmdClockPairB;
  assign rowSelectBN = selN;
  assign memAddrB = addr;
  assign memAddrDupB = addr[dcb_pkg::DUP_HI:dcb_pkg::DUP_LO];
  assign bankAddrB = bank;
  assign {rowStrobeBN, columnStrobeBN, writeEnableBN} = cmdPins;
  assign rowClockEnableB = cke;
  assign memDataBOut = dataOut;
  assign memDataBOe = dataOe;
  assign byteStrobeBOut = dqsOut;
  assign byteStrobeBOe = dqsOe;
  assign selfRefreshActive = (state == dcb_pkg::ST_SREF);
  assign initDone = (state != dcb_pkg::ST_INIT);

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Strobes are only oversampled four times per edge pair; capture
  // sits on the synchronised edge, so pin skew must stay small.
  logic [7:0] dqsS1, dqsS2, dqsPrev;
  logic [63:0] dataS1, dataS2;
  logic [63:0] rdBeat0, next_rdBeat0, rdBeat1, next_rdBeat1;
  logic [7:0] laneDone, next_laneDone;
  logic allDone;
  logic rdPulse;
  logic [2:0] oeHist;
  logic capBlock;

  assign allDone = &laneDone;
  // Sync stages lag the pins: own write strobe edges still show after drive stops
  assign capBlock = dqsOe || (oeHist != 3'h0);

  generate
    for (genvar n = 0; n < dcb_pkg::LANES; n++) begin : gLane
      always_comb begin
        next_rdBeat0[n*8 +: 8] = rdBeat0[n*8 +: 8];
        next_rdBeat1[n*8 +: 8] = rdBeat1[n*8 +: 8];
        next_laneDone[n] = laneDone[n] && !allDone;
        if (!capBlock && dqsS2[n] && !dqsPrev[n]) begin
          next_rdBeat0[n*8 +: 8] = dataS2[n*8 +: 8];
        end
        if (!capBlock && !dqsS2[n] && dqsPrev[n]) begin
          next_rdBeat1[n*8 +: 8] = dataS2[n*8 +: 8];
          next_laneDone[n] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dqsS1 <= 8'h00;
      dqsS2 <= 8'h00;
      dqsPrev <= 8'h00;
      dataS1 <= 64'h0;
      dataS2 <= 64'h0;
      rdBeat0 <= 64'h0;
      rdBeat1 <= 64'h0;
      laneDone <= 8'h00;
      rdPulse <= 1'b0;
      oeHist <= 3'h0;
    end else begin
      oeHist <= {oeHist[1:0], dqsOe};
      dqsS1 <= byteStrobeBIn;
      dqsS2 <= dqsS1;
      dqsPrev <= dqsS2;
      dataS1 <= memDataBIn;
      dataS2 <= dataS1;
      rdBeat0 <= next_rdBeat0;
      rdBeat1 <= next_rdBeat1;
      laneDone <= next_laneDone;
      rdPulse <= allDone;
    end
  end

  assign rdValid = rdPulse;
  assign rdData = {rdBeat1, rdBeat0};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence cmdRise;
    $rose(cmdClockPairB[0]);
  endsequence

  sequence nextRise;
    ##4 $rose(cmdClockPairB[0]);
  endsequence

  clock_period_a: assert property (@(posedge clk) disable iff (!nrst) cmdRise |-> nextRise)
    else $error("command clock period is not four cycles");
  pair_phase_a: assert property (@(posedge clk) disable iff (!nrst)
      (cmdClockPairBN == ~cmdClockPairB) && (cmdClockPairB == {6{cmdClockPairB[0]}}))
    else $error("clock pairs not matched");
  select_timing_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(rowSelectBN) |-> cmdRise)
    else $error("row select moved off clock rise");
  addr_copy_a: assert property (@(posedge clk) disable iff (!nrst)
      memAddrDupB == memAddrB[5:1])
    else $error("duplicate address differs");
  cmd_timing_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed({rowStrobeBN, columnStrobeBN, writeEnableBN, bankAddrB}) |-> cmdRise)
    else $error("command pins moved off clock rise");
  write_window_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(memDataBOe) |-> memDataBOe [*4] ##1 !memDataBOe)
    else $error("write drive not one command clock");
  strobe_centre_a: assert property (@(posedge clk) disable iff (!nrst)
      memDataBOe && $rose(byteStrobeBOut[0]) |-> $past(cmdClockPairB[0]) ##1 $changed(memDataBOut))
    else $error("write strobe not centred");
  init_cke_a: assert property (@(posedge clk) disable iff (!nrst)
      state == dcb_pkg::ST_INIT |-> rowClockEnableB == 4'h0)
    else $error("clock enable high during init");
  sref_cke_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(selfRefreshActive) |-> rowClockEnableB == 4'h0 && !rowStrobeBN && !columnStrobeBN)
    else $error("self-refresh entry wrong");
  wake_first_a: assert property (@(posedge clk) disable iff (!nrst)
      state == dcb_pkg::ST_CMD |-> (~rowSelectBN & ~rowClockEnableB) == 4'h0)
    else $error("command to powered-down row");
  cke_timing_a: assert property (@(posedge clk) disable iff (!nrst)
      $changed(rowClockEnableB) |-> cmdRise)
    else $error("clock enable moved off clock rise");
endmodule
`default_nettype wire

// ===== rtl/dcb_pkg.sv
// Constants, command codes and states for the channel B DDR pin interface.
// Assumes a single 100 MHz core clock; the DRAM command clock is divided from it.
package dcb_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CLK_PAIRS = 6;
  localparam int ROWS = 4;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int LANES = 8;
  localparam int LANE_W = 8;
  localparam int DUP_LO = 1;
  localparam int DUP_HI = 5;
  localparam int IDLE_W = 8;
  localparam int INIT_W = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int INIT_US = 200;
  localparam int INIT_CYC = INIT_US * CLK_MHZ;
  localparam int IDLE_NS = 1000;
  localparam int IDLE_CYC = (IDLE_NS * CLK_MHZ + 999) / 1000;

  // Four core cycles per command clock: rise, strobe up, fall, last
  localparam logic [1:0] PH_RISE = 2'h0;
  localparam logic [1:0] PH_DQS_UP = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Pin values
  // ----------------------------------------------------------------
  localparam logic [3:0] CKE_OFF = 4'h0;
  localparam logic [3:0] CKE_ALL = 4'hf;
  localparam logic [3:0] SEL_ALL_N = 4'h0;
  localparam logic [3:0] SEL_NONE_N = 4'hf;
  localparam logic [3:0] SEL_ONE = 4'h1;
  localparam logic [7:0] DQS_HIGH = 8'hff;
  localparam logic [7:0] DQS_LOW = 8'h00;
  // Row strobe, column strobe, write enable, all active low
  localparam logic [2:0] PINS_NOP = 3'h7;
  localparam logic [2:0] PINS_ACT = 3'h3;
  localparam logic [2:0] PINS_RD = 3'h5;
  localparam logic [2:0] PINS_WR = 3'h4;
  localparam logic [2:0] PINS_PRE = 3'h2;
  localparam logic [2:0] PINS_REF = 3'h1;
  localparam logic [2:0] PINS_MRS = 3'h0;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_MRS = 3'h6
  } dcb_cmd_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_IDLE = 3'h1,
    ST_WAKE = 3'h3,
    ST_ISSUE = 3'h2,
    ST_CMD = 3'h6,
    ST_WDATA = 3'h7,
    ST_SREF = 3'h5
  } dcb_state_t;
endpackage

// ===== sim/dcb_dimm_model.sv
// DIMM-side model for the channel B pin interface: returns read bursts, captures writes.
// Assumes the bench resolves the shared data and strobe wires from both enables.
`timescale 1ns/10ps
`default_nettype none
module dcb_dimm_model (
  input wire logic cmdClk,
  input wire logic [3:0] selN,
  input wire logic [2:0] pins,
  input wire logic [63:0] devDq,
  input wire logic [7:0] devDqs,
  input wire logic devOe,
  input wire logic [63:0] rdBeat0,
  input wire logic [63:0] rdBeat1,
  output logic [63:0] dq,
  output logic [7:0] dqs,
  output logic [63:0] wrBeat0,
  output logic [63:0] wrBeat1
);
  // Strobes parked low between bursts: a toggling idle strobe would look like capture edges
  initial begin
    dq = 64'h5a5a_a5a5_0ff0_f00f;
    dqs = 8'h00;
  end

  // ----------------------------------------------------------------
  // Read return, strobe edges aligned with data
  // ----------------------------------------------------------------
  always @(posedge cmdClk) begin
    #1;
    if (selN !== 4'hf && pins === 3'h5) begin
      #60;
      dq = rdBeat0;
      dqs = 8'hff;
      #40;
      dq = rdBeat1;
      dqs = 8'h00;
      #40;
      dq = ~rdBeat1;
    end
  end

  for (genvar n = 0; n < 8; n++) begin : g_lane
    always @(posedge devDqs[n]) if (devOe) wrBeat0[8*n+:8] = devDq[8*n+:8];
    always @(negedge devDqs[n]) if (devOe) wrBeat1[8*n+:8] = devDq[8*n+:8];
  end
endmodule
`default_nettype wire

// ===== sim/dcb_channel_tb_top.sv
// Self-checking bench for the channel B pin interface with a DIMM model.
// Assumes a shortened power-up count; shared wires resolved here from both enables.
`timescale 1ns/10ps
`default_nettype none
module dcb_channel_tb_top;
  localparam int INIT_SIM = 20;
  logic clk, nrst, reqValid, reqReady, suspendReq, selfRefreshActive, initDone, rdValid;
  dcb_pkg::dcb_cmd_t reqCmd;
  logic [1:0] reqRow, reqBank, bankAddrB;
  logic [12:0] reqAddr, memAddrB;
  logic [63:0] reqWrData0, reqWrData1, memDataBOut, modelDq, rdBeat0, rdBeat1, wrBeat0, wrBeat1;
  logic [127:0] rdData;
  logic [5:0] cmdClockPairB, cmdClockPairBN;
  logic [3:0] rowSelectBN, rowClockEnableB, prevSel, prevCke;
  logic [5:1] memAddrDupB;
  logic rowStrobeBN, columnStrobeBN, writeEnableBN, memDataBOe, byteStrobeBOe, prevClk;
  logic [7:0] byteStrobeBOut, modelDqs;
  wire logic [63:0] memDataBIn = memDataBOe ? memDataBOut : modelDq;
  wire logic [7:0] byteStrobeBIn = byteStrobeBOe ? byteStrobeBOut : modelDqs;
  int failures, comparisons;

  dcb_channel #(.INIT_CYCLES(INIT_SIM)) i_dcb_channel (.clk(clk), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqRow(reqRow),
    .reqBank(reqBank), .reqAddr(reqAddr), .reqWrData0(reqWrData0), .reqWrData1(reqWrData1),
    .suspendReq(suspendReq), .selfRefreshActive(selfRefreshActive), .initDone(initDone),
    .rdValid(rdValid), .rdData(rdData), .cmdClockPairB(cmdClockPairB),
    .cmdClockPairBN(cmdClockPairBN), .rowSelectBN(rowSelectBN), .memAddrB(memAddrB),
    .memAddrDupB(memAddrDupB), .bankAddrB(bankAddrB), .rowStrobeBN(rowStrobeBN),
    .columnStrobeBN(columnStrobeBN), .writeEnableBN(writeEnableBN),
    .rowClockEnableB(rowClockEnableB), .memDataBIn(memDataBIn), .memDataBOut(memDataBOut),
    .memDataBOe(memDataBOe), .byteStrobeBIn(byteStrobeBIn), .byteStrobeBOut(byteStrobeBOut),
    .byteStrobeBOe(byteStrobeBOe));

  dcb_dimm_model i_dcb_dimm_model (.cmdClk(cmdClockPairB[0]), .selN(rowSelectBN),
    .pins({rowStrobeBN, columnStrobeBN, writeEnableBN}), .devDq(memDataBOut),
    .devDqs(byteStrobeBOut), .devOe(byteStrobeBOe), .rdBeat0(rdBeat0), .rdBeat1(rdBeat1),
    .dq(modelDq), .dqs(modelDqs), .wrBeat0(wrBeat0), .wrBeat1(wrBeat1));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return reqReady;
      1: return rowSelectBN != 4'hf;
      2: return rdValid;
      3: return memDataBOe;
      4: return rowClockEnableB == 4'h0;
      5: return selfRefreshActive;
      6: return rowClockEnableB == 4'hf;
      default: return 1'b0;
    endcase
  endfunction

  task automatic wait_for(input int k, input int lim);
    for (int i = 0; i < lim && cond(k) !== 1'b1; i++) tick(1);
    if (cond(k) !== 1'b1) begin
      failures++;
      $display("Error wait %0d expected 1 seen 0", k);
      end_sim();
    end
  endtask

  task automatic issue(input dcb_pkg::dcb_cmd_t c, input logic [1:0] r, input logic [1:0] b,
                       input logic [12:0] a);
    wait_for(0, 300);
    reqCmd = c;
    reqRow = r;
    reqBank = b;
    reqAddr = a;
    reqValid = 1'b1;
    tick(1);
    reqValid = 1'b0;
  endtask

  // Refresh and mode set go to every row; refresh ignores address and bank
  task automatic cmd_check(input dcb_pkg::dcb_cmd_t c, input logic [1:0] r,
                           input logic [1:0] b, input logic [12:0] a, input logic [2:0] p);
    logic all;
    all = (c == dcb_pkg::CMD_REF || c == dcb_pkg::CMD_MRS);
    wait_for(1, 20);
    chk("select", all ? 4'h0 : 4'(~(4'h1 << r)), rowSelectBN);
    chk("pins", p, {rowStrobeBN, columnStrobeBN, writeEnableBN});
    chk("clock rise", 1'b1, cmdClockPairB[0]);
    chk("cke", 4'hf, rowClockEnableB);
    if (c != dcb_pkg::CMD_REF) begin
      chk("addr", a, memAddrB);
      chk("dup", a[5:1], memAddrDupB);
      chk("bank", b, bankAddrB);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_init();
    chk("cke init", 4'h0, rowClockEnableB);
    chk("ready init", 1'b0, reqReady);
    wait_for(6, INIT_SIM + 20);
    chk("init done", 1'b1, initDone);
  endtask

  task automatic s_clocks();
    int rises = 0;
    int highs = 0;
    logic prev = cmdClockPairB[0];
    repeat (16) begin
      tick(1);
      chk("pair equal", {6{cmdClockPairB[0]}}, cmdClockPairB);
      chk("pair inverse", 6'h3f, cmdClockPairB ^ cmdClockPairBN);
      rises += int'(cmdClockPairB[0] && !prev);
      highs += int'(cmdClockPairB[0]);
      prev = cmdClockPairB[0];
    end
    chk("rises", 4, rises);
    chk("highs", 8, highs);
  endtask

  task automatic s_cmds();
    dcb_pkg::dcb_cmd_t cl[4] = '{dcb_pkg::CMD_ACT, dcb_pkg::CMD_PRE, dcb_pkg::CMD_MRS,
                                  dcb_pkg::CMD_REF};
    logic [2:0] pl[4] = '{3'h3, 3'h2, 3'h0, 3'h1};
    for (int i = 0; i < 4; i++) begin
      issue(cl[i], 2'(i), 2'(3 - i), i[0] ? 13'h1fff : 13'h0aaa);
      cmd_check(cl[i], 2'(i), 2'(3 - i), i[0] ? 13'h1fff : 13'h0aaa, pl[i]);
    end
  endtask

  task automatic s_write();
    reqWrData0 = 64'h0123_4567_89ab_cdef;
    reqWrData1 = 64'hfedc_ba98_7654_3210;
    issue(dcb_pkg::CMD_WR, 2'h2, 2'h1, 13'h0155);
    cmd_check(dcb_pkg::CMD_WR, 2'h2, 2'h1, 13'h0155, 3'h4);
    wait_for(3, 20);
    chk("dqs oe", 1'b1, byteStrobeBOe);
    chk("dqs pre", 8'h00, byteStrobeBOut);
    tick(1);
    chk("dqs mid0", 8'hff, byteStrobeBOut);
    chk("data mid0", reqWrData0, memDataBOut);
    tick(1);
    chk("data beat1", reqWrData1, memDataBOut);
    chk("dqs hold", 8'hff, byteStrobeBOut);
    wait_for(0, 20);
    chk("wr beat0", reqWrData0, wrBeat0);
    chk("wr beat1", reqWrData1, wrBeat1);
    // Own write strobes must not be taken for a read return
    repeat (6) begin
      tick(1);
      chk("wr no read", 1'b0, rdValid);
    end
  endtask

  task automatic s_read();
    rdBeat0 = 64'h1122_3344_5566_7788;
    rdBeat1 = 64'h99aa_bbcc_ddee_ff01;
    issue(dcb_pkg::CMD_RD, 2'h3, 2'h2, 13'h0013);
    cmd_check(dcb_pkg::CMD_RD, 2'h3, 2'h2, 13'h0013, 3'h5);
    wait_for(2, 60);
    chk("rd beat0", rdBeat0, rdData[63:0]);
    chk("rd beat1", rdBeat1, rdData[127:64]);
    tick(1);
    chk("rd pulse", 1'b0, rdValid);
  endtask

  task automatic s_idle();
    tick(dcb_pkg::IDLE_CYC / 2);
    chk("cke early", 4'hf, rowClockEnableB);
    wait_for(4, dcb_pkg::IDLE_CYC + 40);
    issue(dcb_pkg::CMD_ACT, 2'h1, 2'h0, 13'h0100);
    cmd_check(dcb_pkg::CMD_ACT, 2'h1, 2'h0, 13'h0100, 3'h3);
  endtask

  task automatic s_suspend();
    wait_for(0, 300);
    suspendReq = 1'b1;
    wait_for(5, 20);
    chk("sr cke", 4'h0, rowClockEnableB);
    chk("sr select", 4'h0, rowSelectBN);
    chk("sr pins", 3'h1, {rowStrobeBN, columnStrobeBN, writeEnableBN});
    chk("sr ready", 1'b0, reqReady);
    tick(30);
    chk("sr hold", 4'h0, rowClockEnableB);
    suspendReq = 1'b0;
    wait_for(6, 20);
    chk("sr exit", 1'b0, selfRefreshActive);
  endtask

  // Selects and clock enables may only move where the command clock rises
  always @(negedge clk) begin
    if (nrst === 1'b1 && (rowSelectBN !== prevSel || rowClockEnableB !== prevCke)) begin
      chk("edge align", 2'h2, {cmdClockPairB[0], prevClk});
    end
    prevSel = rowSelectBN;
    prevCke = rowClockEnableB;
    prevClk = cmdClockPairB[0];
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #500000;
    failures++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    reqValid = 1'b0;
    suspendReq = 1'b0;
    reqCmd = dcb_pkg::CMD_NOP;
    reqRow = 2'h0;
    reqBank = 2'h0;
    reqAddr = 13'h0000;
    reqWrData0 = 64'h0;
    reqWrData1 = 64'h0;
    rdBeat0 = 64'h0;
    rdBeat1 = 64'h0;
    failures = 0;
    comparisons = 0;
    tick(6);
    nrst = 1'b1;
    s_init();
    s_clocks();
    s_cmds();
    s_write();
    s_read();
    s_idle();
    s_suspend();
    end_sim();
  end
endmodule
`default_nettype wire
